// ==== src/edq_pkg.sv ====
// Purpose: constants and types for the edge delay qualifier
// Assumes: 100 MHz aclk, 32-bit AXI4-Lite register access
// Notes: divider code arrives as a 4-bit converter result on pins
//
// Overview of operation
// RL1 - pin voltage becomes 4-bit divider code
// RL2 - code MSB is the polarity bit
// RL3 - single-edge: pol 0 delays rising, 1 falling
// RL4 - dual-edge: both delayed, pol 1 inverts
// RL5 - low set current holds pending edge
// RL6 - set current restored completes held edge
// RL7 - all codes 0..15, ratios 1 to 2^21
// RL8 - edges reach output after delay per variant
// RL9 - short input pulse: no change, timing restarts
// RL10 - single-edge: other direction passes at once
// RL11 - codes 0..7 ratios x8 steps, 8..15 mirrored
// RL12 - output changes after ratio times master period
// RL13 - tick counter cleared on qualifying edge
package edq_pkg;
   // -------------------------------------------------
   // register map
   // -------------------------------------------------
   localparam int ADDR_W = 4;
   localparam logic [ADDR_W-1:0] CTRL_OFS = 4'h0;
   localparam logic [ADDR_W-1:0] PERIOD_OFS = 4'h4;
   localparam logic [ADDR_W-1:0] STATUS_OFS = 4'h8;
   localparam logic [ADDR_W-1:0] COUNT_OFS = 4'hC;
   localparam int CTRL_DUAL_BIT = 0;
   localparam logic CTRL_RST = 1'b0;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // -------------------------------------------------
   // timing
   // -------------------------------------------------
   localparam int CLK_MHZ = 100;
   localparam int MASTER_T_NS = 1000;
   localparam int MASTER_CYC = (MASTER_T_NS * CLK_MHZ + 999) / 1000;
   localparam int PERIOD_W = 16;
   localparam logic [PERIOD_W-1:0] PERIOD_RST = PERIOD_W'(MASTER_CYC);
   localparam int CNT_W = 22;
   localparam int RATIO_STEP = 3;
   // -------------------------------------------------
   // types
   // -------------------------------------------------
   typedef struct packed {
      logic [3:0] code;
      logic iset_low;
      logic pending;
      logic out;
      logic in;
   } edq_status_t;

   // ratio index folds upper codes back onto lower ones
   function automatic logic [CNT_W-1:0] edq_ratio(input logic [3:0] c);
      logic [2:0] idx;
      idx = c[3] ? ~c[2:0] : c[2:0]; // RL11
      edq_ratio = CNT_W'(1) << (RATIO_STEP * idx); // RL7
   endfunction : edq_ratio
endpackage : edq_pkg

// ==== src/edq_top.sv ====
// Purpose: edge delay and pulse qualifier with AXI4-Lite registers
// Assumes: in_pin, div_code_pin and iset_low_pin are asynchronous
// Notes: master oscillator is a clock-enable pulse from a divider
//
// Our own choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
module edq_top import edq_pkg::*; (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic in_pin,
   input wire logic [3:0] div_code_pin,
   input wire logic iset_low_pin,
   output logic out_pin,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   // -------------------------------------------------
   // pin synchronisers
   // -------------------------------------------------
   logic [5:0] sync1_r, sync2_r;
   logic in_d_r;
   logic [3:0] divider_code;
   logic in_s, iset_low_s, polarity_bit;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync1_r <= '0;
         sync2_r <= '0;
         in_d_r <= 1'b0;
      end else begin
         sync1_r <= {iset_low_pin, div_code_pin, in_pin};
         sync2_r <= sync1_r;
         in_d_r <= in_s;
      end
   end
   assign in_s = sync2_r[0];
   assign divider_code = sync2_r[4:1]; // RL1
   assign iset_low_s = sync2_r[5];
   assign polarity_bit = divider_code[3]; // RL2

   // -------------------------------------------------
   // registers
   // -------------------------------------------------
   logic dual_r, dual_nxt;
   logic [PERIOD_W-1:0] period_r, period_nxt;
   logic aw_got_r, aw_got_nxt, w_got_r, w_got_nxt;
   logic [ADDR_W-1:0] waddr_r, waddr_nxt;
   logic [31:0] wdata_r, wdata_nxt;
   logic [3:0] wstrb_r, wstrb_nxt;
   logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
   logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic pending_r, out_r;
   logic [CNT_W-1:0] cnt_r;
   edq_status_t status;

   assign s_axi_awready = !aw_got_r && !bvalid_r;
   assign s_axi_wready = !w_got_r && !bvalid_r;
   assign s_axi_arready = !rvalid_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rresp = rresp_r;
   assign s_axi_rdata = rdata_r;
   assign status = '{code: divider_code, iset_low: iset_low_s, pending: pending_r,
                     out: out_r, in: in_s};

   always_comb begin
      aw_got_nxt = aw_got_r;
      w_got_nxt = w_got_r;
      waddr_nxt = waddr_r;
      wdata_nxt = wdata_r;
      wstrb_nxt = wstrb_r;
      bvalid_nxt = bvalid_r;
      bresp_nxt = bresp_r;
      rvalid_nxt = rvalid_r;
      rresp_nxt = rresp_r;
      rdata_nxt = rdata_r;
      dual_nxt = dual_r;
      period_nxt = period_r;
      if (s_axi_awvalid && s_axi_awready) begin
         aw_got_nxt = 1'b1;
         waddr_nxt = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         w_got_nxt = 1'b1;
         wdata_nxt = s_axi_wdata;
         wstrb_nxt = s_axi_wstrb;
      end
      if (aw_got_r && w_got_r) begin
         aw_got_nxt = 1'b0;
         w_got_nxt = 1'b0;
         bvalid_nxt = 1'b1;
         bresp_nxt = RESP_OKAY;
         unique case (waddr_r)
            CTRL_OFS: begin
               if (wstrb_r[0]) dual_nxt = wdata_r[CTRL_DUAL_BIT];
            end
            PERIOD_OFS: begin
               if (wstrb_r[0]) period_nxt[7:0] = wdata_r[7:0];
               if (wstrb_r[1]) period_nxt[15:8] = wdata_r[15:8];
            end
            STATUS_OFS, COUNT_OFS: ;
            default: bresp_nxt = RESP_SLVERR;
         endcase
      end
      if (bvalid_r && s_axi_bready) bvalid_nxt = 1'b0;
      if (rvalid_r && s_axi_rready) rvalid_nxt = 1'b0;
      if (s_axi_arvalid && s_axi_arready) begin
         rvalid_nxt = 1'b1;
         rresp_nxt = RESP_OKAY;
         unique case (s_axi_araddr)
            CTRL_OFS: rdata_nxt = {31'h0, dual_r};
            PERIOD_OFS: rdata_nxt = {16'h0, period_r};
            STATUS_OFS: rdata_nxt = {24'h0, status};
            COUNT_OFS: rdata_nxt = {10'h0, cnt_r};
            default: begin
               rdata_nxt = 32'h0;
               rresp_nxt = RESP_SLVERR;
            end
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got_r <= 1'b0;
         w_got_r <= 1'b0;
         waddr_r <= '0;
         wdata_r <= 32'h0;
         wstrb_r <= 4'h0;
         bvalid_r <= 1'b0;
         bresp_r <= RESP_OKAY;
         rvalid_r <= 1'b0;
         rresp_r <= RESP_OKAY;
         rdata_r <= 32'h0;
         dual_r <= CTRL_RST;
         period_r <= PERIOD_RST;
      end else begin
         aw_got_r <= aw_got_nxt;
         w_got_r <= w_got_nxt;
         waddr_r <= waddr_nxt;
         wdata_r <= wdata_nxt;
         wstrb_r <= wstrb_nxt;
         bvalid_r <= bvalid_nxt;
         bresp_r <= bresp_nxt;
         rvalid_r <= rvalid_nxt;
         rresp_r <= rresp_nxt;
         rdata_r <= rdata_nxt;
         dual_r <= dual_nxt;
         period_r <= period_nxt;
      end
   end

   // -------------------------------------------------
   // delay core
   // -------------------------------------------------
   logic pending_nxt, out_nxt, tick, edge_in, rise_in, fast_edge, slow_edge;
   logic [PERIOD_W-1:0] tcnt_r, tcnt_nxt;
   logic [CNT_W-1:0] cnt_nxt, ratio;
   assign ratio = edq_ratio(divider_code);
   assign edge_in = in_s != in_d_r;
   assign rise_in = edge_in && in_s;
   // a zero period would stall the oscillator, so treat it as one
   assign tick = pending_r && !iset_low_s && (tcnt_r + 1'b1 >= period_r); // RL5
   assign fast_edge = edge_in && !dual_r && (rise_in == polarity_bit); // RL10
   assign slow_edge = edge_in && !fast_edge && (in_s != out_r); // RL3 RL4 RL8
   assign out_pin = out_r ^ (dual_r & polarity_bit); // RL4

   always_comb begin
      pending_nxt = pending_r;
      out_nxt = out_r;
      cnt_nxt = cnt_r;
      tcnt_nxt = tcnt_r;
      if (pending_r && !iset_low_s) tcnt_nxt = tick ? '0 : tcnt_r + 1'b1;
      if (tick) begin
         cnt_nxt = cnt_r + 1'b1;
         // at-or-above, so a smaller ratio picked mid-timing cannot strand the count
         if (cnt_r + 1'b1 >= ratio) begin // RL12 RL6
            out_nxt = in_s;
            pending_nxt = 1'b0;
         end
      end
      if (fast_edge) begin
         out_nxt = in_s; // RL10
         pending_nxt = 1'b0;
      end else if (slow_edge) begin
         pending_nxt = 1'b1; // RL9
         cnt_nxt = '0; // RL13
         tcnt_nxt = '0;
      end else if (edge_in) begin
         pending_nxt = 1'b0; // RL9
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pending_r <= 1'b0;
         out_r <= 1'b0;
         cnt_r <= '0;
         tcnt_r <= '0;
      end else begin
         pending_r <= pending_nxt;
         out_r <= out_nxt;
         cnt_r <= cnt_nxt;
         tcnt_r <= tcnt_nxt;
      end
   end

   // -------------------------------------------------
   // checks
   // -------------------------------------------------
   AST_CODE_SYNC: assert property (@(posedge aclk) disable iff (!aresetn) // RL1
      ##2 divider_code == $past(div_code_pin, 2)) else $error("code not synced");
   AST_POL_INV: assert property (@(posedge aclk) disable iff (!aresetn) // RL2
      dual_r && !pending_r |-> out_pin == (in_d_r ^ divider_code[3]))
      else $error("polarity wrong");
   AST_SINGLE_HOLD: assert property (@(posedge aclk) disable iff (!aresetn) // RL3
      !dual_r && edge_in && (rise_in != polarity_bit) && in_s != out_r
      |=> pending_r && out_r == $past(out_r)) else $error("delayed edge passed");
   AST_DUAL_START: assert property (@(posedge aclk) disable iff (!aresetn) // RL4
      dual_r && edge_in && in_s != out_r |=> pending_r) else $error("dual not delayed");
   AST_ISET_HOLD: assert property (@(posedge aclk) disable iff (!aresetn) // RL5
      iset_low_s && pending_r && !edge_in |=> $stable(cnt_r) && $stable(out_r))
      else $error("advanced while set current low");
   AST_DONE: assert property (@(posedge aclk) disable iff (!aresetn) // RL6
      tick && cnt_r + 1'b1 >= ratio && !edge_in |=> !pending_r && out_r == $past(in_s))
      else $error("held edge not completed");
   AST_RATIO_MIRROR: assert property (@(posedge aclk) disable iff (!aresetn) // RL11
      ratio == edq_ratio(~divider_code)) else $error("ratio not mirrored");
   AST_RATIO_TOP: assert property (@(posedge aclk) disable iff (!aresetn) // RL7
      divider_code[2:0] == (divider_code[3] ? 3'h0 : 3'h7) |-> ratio == 22'h200000)
      else $error("top ratio wrong");
   AST_SHORT: assert property (@(posedge aclk) disable iff (!aresetn) // RL9
      edge_in && in_s == out_r |=> !pending_r && $stable(out_r))
      else $error("short pulse changed output");
   AST_FAST: assert property (@(posedge aclk) disable iff (!aresetn) // RL10
      fast_edge |=> out_r == $past(in_s) && !pending_r) else $error("fast edge late");
   AST_CLEAR: assert property (@(posedge aclk) disable iff (!aresetn) // RL13
      slow_edge |=> cnt_r == 22'h0) else $error("counter not cleared");
   AST_EARLY: assert property (@(posedge aclk) disable iff (!aresetn) // RL12
      pending_r && cnt_r + 1'b1 < ratio && !edge_in |=> $stable(out_r))
      else $error("output changed early");
endmodule : edq_top

// ==== testbench/edq_far_end.sv ====
// Purpose: far-side logic source for the qualifier input
// Assumes: one aclk domain
// Notes: level moves only just after a rising edge
`timescale 1ns/1ps
module edq_far_end (
   input wire logic aclk,
   input wire logic lvl_req,
   output logic in_pin
);
   initial in_pin = 1'b0;
   // registered so the pin never moves on the sampling edge
   always @(posedge aclk) begin
      in_pin <= lvl_req;
   end
endmodule : edq_far_end

// ==== testbench/edge_delay_qualifier_test.sv ====
// Purpose: self-checking bench for the edge delay qualifier
// Assumes: period register set to 1 so ratios stay short
// Notes: timed trials keep to codes with ratios of 64 or less for run time; codes 7 and 8 only shown while idle
`timescale 1ns/1ps
module edge_delay_qualifier_test;
   import edq_pkg::*;
   logic aclk, aresetn, lvl, iset_low, out_pin, in_pin, old;
   logic awv, awr, wv, wr, bv, br, arv, arr, rv, rr;
   logic [3:0] code, awa, ara, ws;
   logic [31:0] wd, rd, got;
   logic [1:0] bresp, rresp, resp;
   logic [3:0] codes [6] = '{4'h0, 4'h1, 4'h2, 4'hD, 4'hE, 4'hF};
   int n_mismatch, num_checks, cyc, k;
   edq_far_end u_far (.aclk(aclk), .lvl_req(lvl), .in_pin(in_pin));
   edq_top u_dut (.aclk(aclk), .aresetn(aresetn), .in_pin(in_pin), .div_code_pin(code),
      .iset_low_pin(iset_low), .out_pin(out_pin), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
      .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
      .s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
      .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
      .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr));
   // -------------------------------------------------
   // helpers
   // -------------------------------------------------
   function automatic int ratio_of(input logic [3:0] c);
      return 1 << (3 * (c[3] ? 7 - c[2:0] : c[2:0]));
   endfunction : ratio_of
   function automatic logic exp_out(input logic d, input logic [3:0] c, input logic v);
      return v ^ (d & c[3]);
   endfunction : exp_out
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   task automatic conclude;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : conclude
   task automatic cyc_w(input int n);
      repeat (n) @(posedge aclk);
   endtask : cyc_w
   // outputs are looked at mid-cycle, never on the edge that launches them
   task automatic fall_w(input int n);
      repeat (n) @(posedge aclk);
      @(negedge aclk);
   endtask : fall_w
   task automatic axw(input logic [3:0] a, input logic [31:0] d);
      logic ta, tw;
      ta = 0;
      tw = 0;
      awa <= a;
      wd <= d;
      awv <= 1;
      wv <= 1;
      br <= 1;
      while (!ta || !tw) begin
         @(negedge aclk);
         ta = ta || awr;
         tw = tw || wr;
         @(posedge aclk);
         if (ta) awv <= 0;
         if (tw) wv <= 0;
      end
      ta = 0;
      while (!ta) begin
         @(negedge aclk);
         ta = bv;
         resp = bresp;
         @(posedge aclk);
      end
   endtask : axw
   task automatic axr(input logic [3:0] a);
      logic t;
      t = 0;
      ara <= a;
      arv <= 1;
      rr <= 1;
      while (!t) begin
         @(negedge aclk);
         t = arr;
         @(posedge aclk);
      end
      arv <= 0;
      t = 0;
      while (!t) begin
         @(negedge aclk);
         t = rv;
         got = rd;
         resp = rresp;
         @(posedge aclk);
      end
   endtask : axr
   // one input step: settle, move level, then hold and follow checks
   task automatic trial(input logic d, input logic [3:0] c, input logic v);
      logic dly;
      int r;
      r = ratio_of(c);
      dly = d || (v != c[3]);
      axw(CTRL_OFS, 32'(d));
      code <= c;
      fall_w(80);
      check("settled", 32'(out_pin), 32'(exp_out(d, c, lvl)));
      @(posedge aclk);
      axr(STATUS_OFS);
      check("code", 32'(got[7:4]), 32'(c));
      old = lvl;
      lvl <= v;
      // pin register, two sync flops and edge detect add four cycles
      fall_w(dly ? r + 3 : 3);
      check("held", 32'(out_pin), 32'(exp_out(d, c, old)));
      fall_w(1);
      check("follow", 32'(out_pin), 32'(exp_out(d, c, v)));
      @(posedge aclk);
   endtask : trial
   // -------------------------------------------------
   // sequence
   // -------------------------------------------------
   initial begin
      aclk = 0;
      forever #5 aclk = ~aclk;
   end
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_mismatch++;
         conclude();
      end
   end
   initial begin
      {aresetn, lvl, iset_low, awv, wv, br, arv, rr} = '0;
      {code, awa, ara, wd, cyc} = '0;
      ws = 4'hF;
      void'($urandom(32'hA43F));
      repeat (4) @(posedge aclk);
      aresetn <= 1;
      @(posedge aclk);
      axr(CTRL_OFS);
      check("ctrl_rst", got, 32'h0);
      axr(PERIOD_OFS);
      check("period_rst", got, 32'(PERIOD_RST));
      axr(4'h1);
      check("bad_rresp", 32'(resp), 32'(RESP_SLVERR));
      axw(4'h2, 32'h5);
      check("bad_bresp", 32'(resp), 32'(RESP_SLVERR));
      // low lane only: upper byte must keep its reset value
      ws <= 4'h1;
      axw(PERIOD_OFS, 32'h0000FF01);
      ws <= 4'hF;
      check("bresp", 32'(resp), 32'(RESP_OKAY));
      axr(PERIOD_OFS);
      check("period_lane", got, {16'h0, PERIOD_RST[15:8], 8'h01});
      for (int i = 0; i < 8; i++) begin
         trial(i[2], i[1] ? 4'hE : 4'h1, ~i[0]);
      end
      // short pulses: second one would finish early without a restart
      trial(1'b0, 4'h1, 1'b0);
      lvl <= 1;
      cyc_w(4);
      lvl <= 0;
      cyc_w(8);
      lvl <= 1;
      cyc_w(7);
      lvl <= 0;
      fall_w(2);
      check("pulse_hi", 32'(out_pin), 32'h0);
      fall_w(20);
      check("pulse_lo", 32'(out_pin), 32'h0);
      @(posedge aclk);
      // longest-ratio codes, shown while the input is idle
      code <= 4'h7;
      cyc_w(4);
      code <= 4'h8;
      cyc_w(4);
      code <= 4'h0;
      iset_low <= 1;
      cyc_w(4);
      lvl <= 1;
      fall_w(30);
      check("iset_hold", 32'(out_pin), 32'h0);
      @(posedge aclk);
      axr(STATUS_OFS);
      check("iset_stat", got, 32'h0000000D);
      iset_low <= 0;
      fall_w(10);
      check("iset_go", 32'(out_pin), 32'h1);
      @(posedge aclk);
      axr(COUNT_OFS);
      check("count", got, 32'h00000001);
      for (int i = 0; i < 12; i++) begin
         k = $urandom % 6;
         trial(1'($urandom), codes[k], 1'($urandom));
      end
      conclude();
   end
endmodule : edge_delay_qualifier_test
